// [bfm_top.sv]
// bridge fault monitor: short, open load, thermal, undervoltage
// assumes coil and chopper strobes come from logic on clock;
// pins (disable, sensors, level comparators, serial) are async
//
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
`default_nettype none
module bfm_top import bfm_pkg::*; #(
  parameter int SH_W = 20
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic undervolt_in,
  input wire logic bridge_disable_input,
  input wire logic temp_warn_in,
  input wire logic temp_shut_in,
  input wire logic [1:0] hs_on,
  input wire logic [1:0] hs_level_in,
  input wire logic [1:0] coil_polarity,
  input wire logic [1:0] chop_event,
  input wire logic [1:0] target_reached,
  input wire logic [1:0] current_low,
  input wire logic fullstep_mode,
  input wire logic serial_in,
  input wire logic serial_shift,
  output logic serial_out,
  output logic [1:0] bridge_en,
  output logic [1:0] chop_end,
  output logic [1:0] gate_current_sel,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // detection delay in cycles per code
  function automatic logic [5:0] dly_cyc(input logic [1:0] s);
    case (s)
      2'h0: dly_cyc = DLY0_CYC;
      2'h1: dly_cyc = DLY1_CYC;
      2'h2: dly_cyc = DLY2_CYC;
      default: dly_cyc = DLY3_CYC;
    endcase
  endfunction

  // byte-lane mask from strobes
  function automatic logic [31:0] strb_mask(input logic [3:0] st);
    strb_mask = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
  endfunction

  // two-flop synchronisers for pins
  logic [7:0] sy1_reg;
  logic [7:0] sy2_reg;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sy1_reg <= 8'h00;
      sy2_reg <= 8'h00;
    end else begin
      sy1_reg <= {serial_in, hs_level_in, temp_shut_in, temp_warn_in,
                  bridge_disable_input, undervolt_in, 1'b0};
      sy2_reg <= sy1_reg;
    end
  end
  logic uv_s, dis_s, warn_s, shut_s, ser_s;
  logic [1:0] lvl_s;
  assign uv_s = sy2_reg[1];
  assign dis_s = sy2_reg[2];
  assign warn_s = sy2_reg[3];
  assign shut_s = sy2_reg[4];
  assign lvl_s = sy2_reg[6:5];
  assign ser_s = sy2_reg[7];

  // undervoltage or power-up acts as full internal reset
  logic int_rst;
  assign int_rst = !rst_n || uv_s;

  bfm_ctrl_t ctrl_reg;
  logic ot_reg, thermal_warning_flag_reg;
  logic drv_dis;
  // pin disable, zero off time and thermal shutdown
  assign drv_dis = dis_s || (ctrl_reg.off_time == 4'h0) || shut_s || ot_reg;

  // thermal flags follow the sensor levels
  always_ff @(posedge clock) begin
    if (int_rst) begin
      ot_reg <= 1'b0;
      thermal_warning_flag_reg <= 1'b0;
    end else begin
      thermal_warning_flag_reg <= warn_s;
      ot_reg <= shut_s;
    end
  end

  // gate current step, raised in tc modes while warm
  always_ff @(posedge clock) begin
    if (int_rst) begin
      gate_current_sel <= 2'h0;
    end else if (thermal_warning_flag_reg && (ctrl_reg.slope_sel == SLP_TC_LO ||
                              ctrl_reg.slope_sel == SLP_TC_HI)) begin
      gate_current_sel <= 2'(ctrl_reg.slope_sel + 2'h1);
    end else begin
      gate_current_sel <= ctrl_reg.slope_sel;
    end
  end

  logic [1:0] s2g_reg, ol_reg, evt, tog;
  logic [1:0] sc_cnt [2];
  logic [5:0] dcnt [2];
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_coil
      logic pol_q, cyc_off, chop_seen, reach_seen;
      assign tog[gi] = coil_polarity[gi] != pol_q;
      // delay runs while high side on and level not reached
      assign evt[gi] = hs_on[gi] && bridge_en[gi] && !lvl_s[gi] &&
                       !ctrl_reg.detect_off && !cyc_off &&
                       (dcnt[gi] == 6'(dly_cyc(ctrl_reg.delay_sel) - 6'h1));

      // polarity history
      always_ff @(posedge clock) begin
        if (int_rst) begin
          pol_q <= 1'b0;
        end else begin
          pol_q <= coil_polarity[gi];
        end
      end

      // detection delay counter
      always_ff @(posedge clock) begin
        if (int_rst || !hs_on[gi] || !bridge_en[gi] || lvl_s[gi] || cyc_off || ctrl_reg.detect_off) begin
          dcnt[gi] <= 6'h00;
        end else if (!evt[gi]) begin
          dcnt[gi] <= 6'(dcnt[gi] + 6'h1);
        end
      end

      // off for the rest of the high-side phase after a short
      always_ff @(posedge clock) begin
        if (int_rst || !hs_on[gi]) begin
          cyc_off <= 1'b0;
        end else if (evt[gi]) begin
          cyc_off <= 1'b1;
        end
      end

      // short event counter, saturating both ways
      always_ff @(posedge clock) begin
        if (int_rst || drv_dis) begin
          sc_cnt[gi] <= 2'h0;
        end else if (evt[gi] && !tog[gi] && sc_cnt[gi] != SHORT_MAX) begin
          sc_cnt[gi] <= 2'(sc_cnt[gi] + 2'h1);
        end else if (tog[gi] && !evt[gi] && sc_cnt[gi] != 2'h0) begin
          sc_cnt[gi] <= 2'(sc_cnt[gi] - 2'h1);
        end
      end

      // persistent short latch and flag
      always_ff @(posedge clock) begin
        if (int_rst || drv_dis) begin
          s2g_reg[gi] <= 1'b0;
        end else if (sc_cnt[gi] == SHORT_MAX) begin
          s2g_reg[gi] <= 1'b1;
        end
      end

      // bridge enable and chopper abort
      always_ff @(posedge clock) begin
        if (int_rst) begin
          bridge_en[gi] <= 1'b0;
          chop_end[gi] <= 1'b0;
        end else begin
          bridge_en[gi] <= !drv_dis && !s2g_reg[gi] && !evt[gi] && !cyc_off &&
                           sc_cnt[gi] != SHORT_MAX;
          chop_end[gi] <= evt[gi];
        end
      end

      // chopper and target events seen in this polarity period
      always_ff @(posedge clock) begin
        if (int_rst) begin
          chop_seen <= 1'b0;
          reach_seen <= 1'b0;
        end else if (tog[gi]) begin
          chop_seen <= chop_event[gi];
          reach_seen <= target_reached[gi];
        end else begin
          chop_seen <= chop_seen || chop_event[gi];
          reach_seen <= reach_seen || target_reached[gi];
        end
      end

      // open-load flag, updated at each toggle unless current_low is set
      always_ff @(posedge clock) begin
        if (int_rst) begin
          ol_reg[gi] <= 1'b0;
        end else if (tog[gi] && !current_low[gi]) begin
          ol_reg[gi] <= !chop_seen || (fullstep_mode && !reach_seen);
        end
      end
    end
  endgenerate

  // serial path, zero and stalled while in reset
  logic [SH_W-1:0] sh_reg;
  always_ff @(posedge clock) begin
    if (int_rst) begin
      sh_reg <= '0;
      serial_out <= 1'b0;
    end else begin
      if (serial_shift) begin
        sh_reg <= {sh_reg[SH_W-2:0], ser_s};
      end
      serial_out <= sh_reg[SH_W-1];
    end
  end

  bfm_stat_t stat;
  assign stat = '{cur_status: ctrl_reg.cur_scale, drv_en: !drv_dis, ot: ot_reg,
                  thermal_warning_flag: thermal_warning_flag_reg, coil_b_open_flag: ol_reg[1], coil_a_open_flag: ol_reg[0],
                  coil_b_ground_short_flag: s2g_reg[1], coil_a_ground_short_flag: s2g_reg[0]};

  // axi write channel
  bfm_wr_t wr_st;
  logic aw_got, w_got;
  logic [7:0] wa_reg;
  logic [31:0] wd_reg, wm;
  assign wm = strb_mask(s_axi_wstrb);
  always_ff @(posedge clock) begin
    if (int_rst) begin
      wr_st <= WR_IDLE;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      wa_reg <= 8'h00;
      wd_reg <= 32'h0000_0000;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      case (wr_st)
        WR_IDLE: begin
          s_axi_awready <= !aw_got && !(s_axi_awvalid && s_axi_awready);
          s_axi_wready <= !w_got && !(s_axi_wvalid && s_axi_wready);
          if (s_axi_awvalid && s_axi_awready) begin
            aw_got <= 1'b1;
            wa_reg <= s_axi_awaddr;
          end
          if (s_axi_wvalid && s_axi_wready) begin
            w_got <= 1'b1;
            wd_reg <= (32'(ctrl_reg) & ~wm) | (s_axi_wdata & wm);
          end
          if (aw_got && w_got) begin
            wr_st <= WR_RESP;
            s_axi_bvalid <= 1'b1;
            if (wa_reg[7:2] == CTRL_ADDR[7:2] || wa_reg[7:2] == STAT_ADDR[7:2]) begin
              s_axi_bresp <= RESP_OKAY;
            end else begin
              s_axi_bresp <= RESP_SLVERR;
            end
          end
        end
        WR_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            wr_st <= WR_IDLE;
          end
        end
        default: wr_st <= WR_IDLE;
      endcase
    end
  end

  // control register, cleared by undervoltage
  always_ff @(posedge clock) begin
    if (int_rst) begin
      ctrl_reg <= CTRL_RST;
    end else if (wr_st == WR_IDLE && aw_got && w_got &&
                 wa_reg[7:2] == CTRL_ADDR[7:2]) begin
      ctrl_reg <= wd_reg[13:0];
    end
  end

  // axi read channel
  always_ff @(posedge clock) begin
    if (int_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      if (s_axi_araddr[7:2] == CTRL_ADDR[7:2]) begin
        s_axi_rdata <= 32'(ctrl_reg);
        s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_araddr[7:2] == STAT_ADDR[7:2]) begin
        s_axi_rdata <= 32'(stat);
        s_axi_rresp <= RESP_OKAY;
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // checks on the protection paths
  default clocking cb @(posedge clock); endclocking
  default disable iff (int_rst);

  AST_SHORT_OFF: assert property (evt[0] |=> !bridge_en[0] && chop_end[0])
    else $error("short did not switch coil a off");
  AST_CNT_DEC: assert property (tog[0] && !evt[0] && !drv_dis && sc_cnt[0] != 2'h0
    |=> sc_cnt[0] == 2'($past(sc_cnt[0]) - 2'h1))
    else $error("short counter not decremented");
  AST_SHUT: assert property (sc_cnt[0] == SHORT_MAX && !drv_dis
    |=> s2g_reg[0] ##1 !bridge_en[0])
    else $error("counter at limit did not shut bridge");
  AST_FLAG_CLR: assert property (drv_dis |=> s2g_reg == 2'h0 && sc_cnt[0] == 2'h0)
    else $error("short flags not cleared while disabled");
  AST_DET_OFF: assert property (ctrl_reg.detect_off |-> evt == 2'h0)
    else $error("short seen with detection off");
  AST_DELAY: assert property ($rose(evt[0]) |-> dcnt[0] == 6'(dly_cyc(ctrl_reg.delay_sel) - 6'h1))
    else $error("short flagged at wrong delay");
  AST_OL_HOLD: assert property (tog[0] && current_low[0] |=> $stable(ol_reg[0]))
    else $error("open flag changed at low current");
  AST_TC: assert property (thermal_warning_flag_reg && ctrl_reg.slope_sel == SLP_TC_LO && $stable(ctrl_reg)
    |=> gate_current_sel == SLP_TC_HI)
    else $error("gate current not raised when warm");
  AST_OT: assert property (shut_s |=> ot_reg && !stat.drv_en ##1 bridge_en == 2'h0)
    else $error("thermal shutdown not enforced");
  AST_UV_SER: assert property (@(posedge clock) disable iff (!rst_n)
    uv_s |=> serial_out == 1'b0 && ctrl_reg == CTRL_RST)
    else $error("serial out active under undervoltage");

  // reset side effects and the remaining flag paths
  AST_UV_OFF: assert property (@(posedge clock) disable iff (!rst_n)
    uv_s |=> bridge_en == 2'h0 && gate_current_sel == 2'h0)
    else $error("bridges or gate step active under undervoltage");
  AST_BUS_RST: assert property (@(posedge clock) disable iff (1'b0)
    int_rst |=> !s_axi_awready && !s_axi_wready && !s_axi_arready)
    else $error("bus ready while held in reset");
  AST_HOLD3: assert property (s2g_reg[0] && !drv_dis |=> !bridge_en[0])
    else $error("bridge released while short flag set");
  AST_WARN: assert property (warn_s |=> thermal_warning_flag_reg)
    else $error("warning flag missing");
  AST_OL_FULL: assert property (tog[0] && !current_low[0] && fullstep_mode && !g_coil[0].reach_seen
    |=> ol_reg[0])
    else $error("missed target not flagged in fullstep");
  AST_OL_SET: assert property (tog[0] && !current_low[0] && !g_coil[0].chop_seen
    |=> ol_reg[0])
    else $error("open coil not flagged");
endmodule
`default_nettype wire

// [bfm_pkg.sv]
// constants, field layouts and types of the bridge fault monitor
// assumes one 10 MHz clock; registers sit on an axi4-lite slave
// Summary of operation
// - short detected: bridge off, end cycle, count
// - polarity change decrements short counter
// - counter at three: mosfets off until re-enable
// - per-coil short flags, cleared while disabled
// - short: voltage misses level within delay
// - one bit switches short detection off
// - two-bit code picks 3.2/1.6/1.2/0.8 us
// - open flag: no chopper event last period
// - open flag kept below 1/16 current
// - open flag updates on toggle, informational
// - fullstep: missed target current raises open
// - warning flag; react to shutdown threshold
// - shutdown threshold disables driver, sets flag
// - tc slope modes add one gate step
// - undervoltage resets logic, mosfets off, zeros
// - undervoltage: serial output zero, no passthrough
// - undervoltage clears scale; status reads zero
// - power-up: serial held, bus ignored, cleared
// - disable pin high disables all mosfets
// - zero off-time acts as driver disable
package bfm_pkg;
  localparam int CLK_NS = 100;
  localparam int DLY0_NS = 3200;
  localparam int DLY1_NS = 1600;
  localparam int DLY2_NS = 1200;
  localparam int DLY3_NS = 800;
  localparam logic [5:0] DLY0_CYC = 6'((DLY0_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [5:0] DLY1_CYC = 6'((DLY1_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [5:0] DLY2_CYC = 6'((DLY2_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [5:0] DLY3_CYC = 6'((DLY3_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [1:0] SHORT_MAX = 2'h3;
  localparam logic [1:0] SLP_TC_LO = 2'h1;
  localparam logic [1:0] SLP_TC_HI = 2'h2;
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STAT_ADDR = 8'h04;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [13:0] CTRL_RST = 14'h0000;
  // control word, bits 13..0 of the control register
  typedef struct packed {
    logic [4:0] cur_scale;
    logic [3:0] off_time;
    logic [1:0] slope_sel;
    logic [1:0] delay_sel;
    logic detect_off;
  } bfm_ctrl_t;
  // status word, bits 11..0 of the status register
  typedef struct packed {
    logic [4:0] cur_status;
    logic drv_en;
    logic ot;
    logic thermal_warning_flag;
    logic coil_b_open_flag;
    logic coil_a_open_flag;
    logic coil_b_ground_short_flag;
    logic coil_a_ground_short_flag;
  } bfm_stat_t;
  typedef enum logic [0:0] {
    WR_IDLE = 1'b0,
    WR_RESP = 1'b1
  } bfm_wr_t;
endpackage

// [bfm_bridge_model.sv]
// behavioural model of the two external bridges and coils
// assumes bridge_en from the monitor, hs_on and short_on from the bench
`timescale 1ns/10ps
`default_nettype none
module bfm_bridge_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [1:0] bridge_en,
  input wire logic [1:0] hs_on,
  input wire logic [1:0] short_on,
  output logic [1:0] hs_level_in
);
  // coil voltage rises one cycle after turn-on, well inside the delay
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hs_level_in <= 2'b00;
    end else begin
      hs_level_in <= bridge_en & hs_on & ~short_on;
    end
  end
endmodule
`default_nettype wire

// [bfm_top_test.sv]
// self-checking bench of the bridge fault monitor
// assumes bfm_pkg, bfm_top and the bridge model are compiled first
`timescale 1ns/10ps
`default_nettype none
module bfm_top_test import bfm_pkg::*; ;
  logic clock = 0, rst_n = 0, uv = 0, dis = 0, tw = 0, ts = 0, fs = 0, sin = 0, ssh = 0, sout;
  logic [1:0] hs_on = 0, lvl, pol = 0, chop = 0, tgt = 0, cl = 0, ben, cend, gsel, short_on = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  int err_count = 0;
  int checks_done = 0;
  bfm_ctrl_t c;
  bfm_stat_t s;
  logic [31:0] d;
  logic [1:0] r;
  int cyc;
  logic p;

  bfm_top dut (.clock(clock), .rst_n(rst_n), .undervolt_in(uv), .bridge_disable_input(dis),
    .temp_warn_in(tw), .temp_shut_in(ts), .hs_on(hs_on), .hs_level_in(lvl), .coil_polarity(pol),
    .chop_event(chop), .target_reached(tgt), .current_low(cl), .fullstep_mode(fs), .serial_in(sin),
    .serial_shift(ssh), .serial_out(sout), .bridge_en(ben), .chop_end(cend), .gate_current_sel(gsel),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  bfm_bridge_model bridges (.clock(clock), .rst_n(rst_n), .bridge_en(ben), .hs_on(hs_on),
    .short_on(short_on), .hs_level_in(lvl));

  // free-running 10 MHz clock
  initial begin
    forever #50 clock = ~clock;
  end

  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n;
    @(posedge clock);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (n == 50) begin
      check(1'b0, "write timeout");
      stop_test();
    end
    bready <= 1'b0;
    rs = bresp;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (n == 50) begin
      check(1'b0, "read timeout");
      stop_test();
    end
    rready <= 1'b0;
    v = rdata;
    rs = rresp;
  endtask

  // write control word, let pin syncs settle
  task automatic cfg(input bfm_ctrl_t k);
    logic [1:0] rs;
    wr(CTRL_ADDR, 32'(k), rs);
    check(rs === RESP_OKAY, "control write response");
    repeat (4) @(posedge clock);
  endtask

  task automatic st();
    logic [1:0] rs;
    rd(STAT_ADDR, d, rs);
    s = bfm_stat_t'(d[11:0]);
  endtask

  // one high-side phase on coil a; measure cycles until the bridge drops
  task automatic short_once();
    @(posedge clock);
    hs_on <= 2'b01;
    p = 1'b0;
    for (cyc = 0; cyc < 60; cyc++) begin
      @(posedge clock);
      if (cend[0] === 1'b1) p = 1'b1;
      if (ben[0] === 1'b0) break;
    end
    hs_on <= 2'b00;
    repeat (4) @(posedge clock);
  endtask

  task automatic toggle(input int n);
    repeat (n) begin
      @(posedge clock);
      pol[0] <= ~pol[0];
      repeat (2) @(posedge clock);
    end
  endtask

  task automatic sc_short();
    c = '{cur_scale: 5'h0a, off_time: 4'h1, slope_sel: 2'h0, delay_sel: 2'h3, detect_off: 1'b0};
    cfg(c);
    check(ben === 2'b11, "nonzero off time enables");
    short_on <= 2'b01;
    repeat (3) begin
      short_once();
      check(cyc >= 32'(DLY3_CYC) && cyc <= 32'(DLY3_CYC) + 4, "short delay");
      check(p, "chopper cycle ended");
    end
    check(ben === 2'b10, "bridge held off at three");
    st();
    check(s.coil_a_ground_short_flag === 1'b1 && s.coil_b_ground_short_flag === 1'b0, "short flag a");
    dis <= 1'b1;
    repeat (4) @(posedge clock);
    check(ben === 2'b00, "disable pin");
    st();
    check(s.coil_a_ground_short_flag === 1'b0, "flag cleared by disable");
    dis <= 1'b0;
    repeat (4) @(posedge clock);
    check(ben === 2'b11, "re-enable releases bridge");
    short_once();
    check(ben[0] === 1'b1, "counter restarted at zero");
    toggle(1);
    short_once();
    short_once();
    check(ben[0] === 1'b1, "toggle decrements");
    toggle(3);
    short_once();
    short_once();
    check(ben[0] === 1'b1, "counter floors at zero");
    c.off_time = 4'h0;
    cfg(c);
    check(ben === 2'b00, "zero off time disables");
    c.off_time = 4'h1;
    c.detect_off = 1'b1;
    cfg(c);
    hs_on <= 2'b01;
    repeat (40) begin
      @(posedge clock);
      check(ben[0] === 1'b1, "detection switched off");
    end
    hs_on <= 2'b00;
    short_on <= 2'b00;
  endtask

  task automatic sc_thermal();
    c = '{cur_scale: 5'h0a, off_time: 4'h1, slope_sel: SLP_TC_LO, delay_sel: 2'h0, detect_off: 1'b0};
    cfg(c);
    tw <= 1'b1;
    repeat (6) @(posedge clock);
    check(gsel === SLP_TC_LO + 2'h1, "gate step raised");
    st();
    check(s.thermal_warning_flag === 1'b1 && s.ot === 1'b0, "warning flag");
    ts <= 1'b1;
    repeat (4) @(posedge clock);
    check(ben === 2'b00, "thermal shutdown");
    st();
    check(s.ot === 1'b1 && s.drv_en === 1'b0, "shutdown flag");
    ts <= 1'b0;
    tw <= 1'b0;
    repeat (6) @(posedge clock);
    check(gsel === SLP_TC_LO && ben === 2'b11, "slope and bridge back");
  endtask

  task automatic sc_open();
    toggle(2);
    st();
    check(s.coil_a_open_flag === 1'b1, "open flag set");
    check(ben === 2'b11, "no protective action");
    chop <= 2'b01;
    @(posedge clock);
    chop <= 2'b00;
    toggle(1);
    st();
    check(s.coil_a_open_flag === 1'b0, "open flag cleared");
    cl <= 2'b01;
    toggle(1);
    st();
    check(s.coil_a_open_flag === 1'b0, "low current holds flag");
    cl <= 2'b00;
    fs <= 1'b1;
    chop <= 2'b01;
    @(posedge clock);
    chop <= 2'b00;
    toggle(1);
    st();
    check(s.coil_a_open_flag === 1'b1, "fullstep target missed");
    chop <= 2'b01;
    tgt <= 2'b01;
    @(posedge clock);
    chop <= 2'b00;
    tgt <= 2'b00;
    toggle(1);
    st();
    check(s.coil_a_open_flag === 1'b0, "fullstep target reached");
    fs <= 1'b0;
  endtask

  task automatic sc_undervolt();
    sin <= 1'b1;
    uv <= 1'b1;
    repeat (4) @(posedge clock);
    repeat (8) begin
      ssh <= 1'b1;
      @(posedge clock);
      check(sout === 1'b0 && ben === 2'b00, "serial and bridges quiet");
    end
    ssh <= 1'b0;
    uv <= 1'b0;
    repeat (4) @(posedge clock);
    repeat (24) begin
      ssh <= 1'b1;
      @(posedge clock);
    end
    ssh <= 1'b0;
    repeat (2) @(posedge clock);
    check(sout === 1'b1, "serial path passes after undervoltage");
    rd(CTRL_ADDR, d, r);
    check(d === 32'h0000_0000, "control cleared");
    st();
    check(s.cur_status === 5'h00, "scale status zero");
  endtask

  // main sequence
  initial begin
    repeat (10) @(posedge clock);
    check(awready === 1'b0 && arready === 1'b0, "bus ignored in reset");
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    rd(CTRL_ADDR, d, r);
    check(d === 32'h0000_0000, "control reset value");
    st();
    check(d === 32'h0000_0000, "status reset value");
    rd(8'h40, d, r);
    check(r === RESP_SLVERR, "unmapped read");
    sc_short();
    sc_thermal();
    sc_open();
    sc_undervolt();
    stop_test();
  end
endmodule
`default_nettype wire
